// >>> logic/tcc_defs.svh
// register offsets, field positions, reset values for the capture/compare channels
// Operation
// - edge selector 00 off, 01 rising, 10 falling, 11 either edge.
// - edge control bits 7-6 channel 4, 5-4 ch1, 3-2 ch2, 1-0 ch3.
// - reset clears every edge selector pair, all captures disabled.
// - capture 4 works only while function select is one, else compare 5.
// - capture channels independent; same-period edges latch the same count.
// - detected edge copies the full 16-bit count in one transfer.
// - capture latches on the phase opposite the counter increment.
// - reset leaves captures 1-3 unchanged; they are read-only byte pairs.
// - high-byte capture read blocks transfer one cycle; capture delayed, kept.
// - shared register is capture 4 when select is one, compare 5 otherwise.
// - reset loads all ones into the shared register.
// - five compare channels, each own value and comparator, checked once per count period.
// - match sets flag; interrupt requested when enable bit is set.
// - compare 2-5 mode/level pair selects the pin action on a match.
// - pin action applies on every match, flag cleared or not.
// - compare 1 match can drive any of five pins via mask and data.
// - reset loads all ones into the four compare value registers.
// - compare value registers fully readable and writable.
// - high-byte compare write blocks that channel's comparison one cycle.
// - mode/level 00 disconnect, 01 toggle, 10 drive low, 11 drive high.
// - compare 1 match: masked pins take compare 1 pin data bits.
// - flags clear by writing one; writing zero leaves them.
// - enable bit matches flag position; one enables that interrupt.
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

//------------------------------------------------------------------------------
// byte offsets
//------------------------------------------------------------------------------
`define TCC_ADDR_W        16
`define TCC_OFF_CAP1      16'h1010
`define TCC_OFF_CAP2      16'h1012
`define TCC_OFF_CAP3      16'h1014
`define TCC_OFF_CMP1      16'h1016
`define TCC_OFF_CMP2      16'h1018
`define TCC_OFF_CMP3      16'h101a
`define TCC_OFF_CMP4      16'h101c
`define TCC_OFF_SHARED    16'h101e
`define TCC_OFF_PINMASK   16'h100c
`define TCC_OFF_PINDATA   16'h100d
`define TCC_OFF_COUNT     16'h100e
`define TCC_OFF_ACTION    16'h1020
`define TCC_OFF_EDGE      16'h1021
`define TCC_OFF_IRQEN     16'h1022
`define TCC_OFF_FLAG      16'h1023
`define TCC_OFF_FUNCSEL   16'h1026

//------------------------------------------------------------------------------
// fields and reset values
//------------------------------------------------------------------------------
`define TCC_FUNCSEL_BIT   2
`define TCC_PIN_LSB       3
`define TCC_CMP_RESET     16'hffff
`define TCC_EDGE_RESET    8'h00
`define TCC_PRESCALE      4

`endif

// >>> logic/tcc_pkg.sv
// types for the capture/compare channels
package tcc_pkg;
    // edge selector encodings
    typedef enum logic [1:0] {
        EDGE_OFF     = 2'h0,
        EDGE_RISE    = 2'h1,
        EDGE_FALL    = 2'h2,
        EDGE_ANY     = 2'h3
    } edge_sel_t;

    // compare pin actions
    typedef enum logic [1:0] {
        ACT_NONE     = 2'h0,
        ACT_TOGGLE   = 2'h1,
        ACT_LOW      = 2'h2,
        ACT_HIGH     = 2'h3
    } pin_act_t;

    // register bus request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    // complete block state
    typedef struct packed {
        logic [15:0]      count;
        logic [1:0]       pre;
        logic [2:0][15:0] cap;
        logic [4:0][15:0] cmp;
        logic [4:0]       cmpBlock;
        logic [3:0]       capBlock;
        logic [3:0]       capPend;
        logic [3:0]       pinPrev;
        logic [7:0]       edgeCtl;
        logic [7:0]       action;
        logic [4:0]       pinMask;
        logic [4:0]       pinData;
        logic             funcSel;
        logic [7:0]       flag;
        logic [7:0]       irqEn;
        logic [4:0]       pins;
        logic [7:0]       rdata;
        logic             irq;
        logic [7:0]       wrHigh;
    } state_t;
endpackage : tcc_pkg

// >>> logic/timer_capture_compare.sv
// capture and compare channels of a 16-bit free-running timer
`timescale 1ns/1ps
`include "tcc_defs.svh"

module timer_capture_compare (
    input  wire logic                 sys_clk,
    input  wire logic                 arst_n,
    input  wire tcc_pkg::bus_req_t    busReq,
    output logic [7:0]                rdData,
    input  wire logic [3:0]           capPins,
    output logic [4:0]                cmpPins,
    output logic                      irqReq
);
    tcc_pkg::state_t s_q;
    tcc_pkg::state_t s_d;

    // edge selector field for pins 0..3 (ch1, ch2, ch3, ch4)
    function automatic logic [1:0] edgeSel(input logic [7:0] ctl, input int ch);
        logic [1:0] r;
        r = 2'h0;
        case (ch)
            0: r = ctl[5:4];
            1: r = ctl[3:2];
            2: r = ctl[1:0];
            default: r = ctl[7:6];
        endcase
        return r;
    endfunction : edgeSel

    function automatic logic [15:0] regWord(input tcc_pkg::state_t st, input int idx);
        logic [15:0] r;
        r = 16'h0000;
        if (idx < 3) begin
            r = st.cap[idx];
        end else begin
            r = st.cmp[idx-3];
        end
        return r;
    endfunction : regWord

    //--------------------------------------------------------------------------
    // next-state logic
    //--------------------------------------------------------------------------
    always_comb begin
        logic       tick;
        logic       hit;
        logic [1:0] es;
        logic       rise;
        logic       fall;
        logic [4:0] ocMatch;
        logic [4:0] nextPins;
        logic [1:0] act;
        logic [15:0] word;
        int         idx;
        s_d = s_q;
        tick = 1'b0;
        ocMatch = 5'h00;
        nextPins = s_q.pins;
        idx = 0;
        word = 16'h0000;
        act = 2'h0;
        es = 2'h0;
        rise = 1'b0;
        fall = 1'b0;
        hit = 1'b0;

        // prescaled free-running counter; increments at the end of a count period
        s_d.pre = s_q.pre + 2'h1;
        if (s_q.pre == 2'(`TCC_PRESCALE - 1)) begin
            tick = 1'b1;
            s_d.count = s_q.count + 16'h0001;
        end

        // one-cycle inhibits expire unless renewed below
        s_d.capBlock = 4'h0;
        s_d.cmpBlock = 5'h00;
        s_d.pinPrev = capPins;

        // capture channels; latch the stable current count, counter updates after
        for (int c = 0; c < 4; c++) begin
            es = edgeSel(s_q.edgeCtl, c);
            rise = capPins[c] & ~s_q.pinPrev[c];
            fall = ~capPins[c] & s_q.pinPrev[c];
            hit = (es[0] & rise) | (es[1] & fall);
            if (c == 3 && !s_q.funcSel) begin
                hit = 1'b0;
            end
            // flag raised at detection, even when the transfer is deferred
            if (hit) begin
                s_d.flag[2-c+(c==3 ? 4 : 0)] = 1'b1;
            end
            if (hit || s_q.capPend[c]) begin
                if (s_q.capBlock[c]) begin
                    s_d.capPend[c] = 1'b1;
                end else begin
                    s_d.capPend[c] = 1'b0;
                    // whole count, same value for all channels this period
                    if (c < 3) begin
                        s_d.cap[c] = s_q.count;
                    end else begin
                        s_d.cmp[4] = s_q.count;
                    end
                end
                if (!hit) begin
                    s_d.capPend[c] = s_q.capBlock[c];
                end
            end
        end

        // comparators, once per count period, skipped after a high-byte write
        for (int k = 0; k < 5; k++) begin
            if (tick && s_q.cmp[k] == s_q.count && !s_q.cmpBlock[k]) begin
                if (k < 4 || !s_q.funcSel) begin
                    ocMatch[k] = 1'b1;
                    s_d.flag[7-k] = 1'b1;
                end
            end
        end

        // pin actions for channels 2-5, on every match
        for (int k = 1; k < 5; k++) begin
            act = s_q.action[7-2*(k-1) -: 2];
            if (ocMatch[k]) begin
                case (act)
                    tcc_pkg::ACT_TOGGLE: nextPins[k] = ~s_q.pins[k];
                    tcc_pkg::ACT_LOW:    nextPins[k] = 1'b0;
                    tcc_pkg::ACT_HIGH:   nextPins[k] = 1'b1;
                    default:             nextPins[k] = s_q.pins[k];
                endcase
            end
        end
        // channel 1 drives masked pins, overriding others; mask bit 7 is pin 0
        if (ocMatch[0]) begin
            for (int p = 0; p < 5; p++) begin
                if (s_q.pinMask[4-p]) begin
                    nextPins[p] = s_q.pinData[4-p];
                end
            end
        end
        s_d.pins = nextPins;

        // register reads: data one cycle later
        s_d.rdata = 8'h00;
        if (busReq.rd) begin
            if (busReq.addr >= `TCC_OFF_CAP1 && busReq.addr <= `TCC_OFF_SHARED + 16'h0001) begin
                idx = int'((busReq.addr - `TCC_OFF_CAP1) >> 1);
                word = regWord(s_q, idx);
                s_d.rdata = busReq.addr[0] ? word[7:0] : word[15:8];
                if (!busReq.addr[0] && idx < 3) begin
                    s_d.capBlock[idx] = 1'b1;
                end
                if (!busReq.addr[0] && idx == 7) begin
                    s_d.capBlock[3] = 1'b1;
                end
            end else if (busReq.addr == `TCC_OFF_PINMASK) begin
                s_d.rdata = {s_q.pinMask, 3'h0};
            end else if (busReq.addr == `TCC_OFF_PINDATA) begin
                s_d.rdata = {s_q.pinData, 3'h0};
            end else if (busReq.addr == `TCC_OFF_COUNT) begin
                s_d.rdata = s_q.count[15:8];
            end else if (busReq.addr == `TCC_OFF_COUNT + 16'h0001) begin
                s_d.rdata = s_q.count[7:0];
            end else if (busReq.addr == `TCC_OFF_ACTION) begin
                s_d.rdata = s_q.action;
            end else if (busReq.addr == `TCC_OFF_EDGE) begin
                s_d.rdata = s_q.edgeCtl;
            end else if (busReq.addr == `TCC_OFF_IRQEN) begin
                s_d.rdata = s_q.irqEn;
            end else if (busReq.addr == `TCC_OFF_FLAG) begin
                s_d.rdata = s_q.flag;
            end else if (busReq.addr == `TCC_OFF_FUNCSEL) begin
                s_d.rdata = {5'h00, s_q.funcSel, 2'h0};
            end
        end

        // register writes; flags set this cycle win over a clear
        if (busReq.wr) begin
            if (busReq.addr >= `TCC_OFF_CMP1 && busReq.addr <= `TCC_OFF_SHARED + 16'h0001) begin
                idx = int'((busReq.addr - `TCC_OFF_CMP1) >> 1);
                if (!(idx == 4 && s_q.funcSel)) begin
                    if (busReq.addr[0]) begin
                        s_d.cmp[idx][7:0] = busReq.wdata;
                    end else begin
                        s_d.cmp[idx][15:8] = busReq.wdata;
                        s_d.cmpBlock[idx] = 1'b1;
                    end
                end
            end else if (busReq.addr == `TCC_OFF_PINMASK) begin
                s_d.pinMask = busReq.wdata[7:3];
            end else if (busReq.addr == `TCC_OFF_PINDATA) begin
                s_d.pinData = busReq.wdata[7:3];
            end else if (busReq.addr == `TCC_OFF_ACTION) begin
                s_d.action = busReq.wdata;
            end else if (busReq.addr == `TCC_OFF_EDGE) begin
                s_d.edgeCtl = busReq.wdata;
            end else if (busReq.addr == `TCC_OFF_IRQEN) begin
                s_d.irqEn = busReq.wdata;
            end else if (busReq.addr == `TCC_OFF_FLAG) begin
                s_d.flag = s_d.flag & ~(busReq.wdata & ~(s_d.flag & ~s_q.flag));
            end else if (busReq.addr == `TCC_OFF_FUNCSEL) begin
                s_d.funcSel = busReq.wdata[`TCC_FUNCSEL_BIT];
            end
        end

        // interrupt request from enabled flags
        s_d.irq = |(s_d.flag & s_d.irqEn);
        s_d.wrHigh = 8'h00;
    end

    //--------------------------------------------------------------------------
    // state register; capture values 1-3 have no reset
    //--------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q.count    <= 16'h0000;
            s_q.pre      <= 2'h0;
            s_q.cmp      <= {5{`TCC_CMP_RESET}};
            s_q.cmpBlock <= 5'h00;
            s_q.capBlock <= 4'h0;
            s_q.capPend  <= 4'h0;
            s_q.pinPrev  <= 4'h0;
            s_q.edgeCtl  <= `TCC_EDGE_RESET;
            s_q.action   <= 8'h00;
            s_q.pinMask  <= 5'h00;
            s_q.pinData  <= 5'h00;
            s_q.funcSel  <= 1'b0;
            s_q.flag     <= 8'h00;
            s_q.irqEn    <= 8'h00;
            s_q.pins     <= 5'h00;
            s_q.rdata    <= 8'h00;
            s_q.irq      <= 1'b0;
            s_q.wrHigh   <= 8'h00;
            // capture values deliberately left alone: they hold through reset
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flip-flops
    assign rdData  = s_q.rdata;
    assign cmpPins = s_q.pins;
    assign irqReq  = s_q.irq;
endmodule : timer_capture_compare

// >>> tb/tcc_event_source.sv
// partner model driving the capture event pins
`timescale 1ns/1ps
module tcc_event_source (
    input  wire logic [3:0] target,
    input  wire logic       sys_clk,
    output logic      [3:0] capPins = 4'h0
);
    // events change just after an edge, held as levels between
    always @(posedge sys_clk) begin
        capPins <= target;
    end
endmodule : tcc_event_source

// >>> tb/timer_capture_compare_asserts.sv
// port assertions for the capture/compare channels
`timescale 1ns/1ps
module timer_capture_compare_asserts (
    input wire logic              sys_clk,
    input wire logic              arst_n,
    input wire tcc_pkg::bus_req_t busReq,
    input wire logic [7:0]        rdData,
    input wire logic [3:0]        capPins,
    input wire logic [4:0]        cmpPins,
    input wire logic              irqReq
);
    logic [1:0] touched_q;
    logic       cmpWr;
    logic       irqWr;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // bus decodes
    assign cmpWr = busReq.wr && busReq.addr inside {[16'h1016:16'h101d]};
    assign irqWr = busReq.wr && busReq.addr inside {16'h1022, 16'h1023};

    // marks registers written since reset
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            touched_q <= 2'h0;
        end else begin
            touched_q <= touched_q | {busReq.wr && busReq.addr == 16'h1021, cmpWr};
        end
    end

    sequence wrAddr(a);
        busReq.wr && busReq.addr == a;
    endsequence
    sequence readBack;
        busReq.rd && busReq.addr == $past(busReq.addr);
    endsequence

    edge_readback_a:
        assert property (wrAddr(16'h1021) ##1 readBack |=> rdData == $past(busReq.wdata, 2))
        else $error("edge control readback wrong");
    cmp_readback_a:
        assert property (cmpWr ##1 readBack |=> rdData == $past(busReq.wdata, 2))
        else $error("compare value readback wrong");
    edge_reset_a:
        assert property (busReq.rd && busReq.addr == 16'h1021 && !touched_q[1] |=> rdData == 8'h00)
        else $error("edge control not clear after reset");
    cmp_reset_a:
        assert property (busReq.rd && busReq.addr inside {[16'h1016:16'h101d]} && !touched_q[0]
            |=> rdData == 8'hff)
        else $error("compare value not all ones after reset");
    pin_spacing_a:
        assert property ($changed(cmpPins) |=> $stable(cmpPins) [*3])
        else $error("compare pins changed within one count");
    irq_fall_a:
        assert property ($fell(irqReq) |-> $past(irqWr) || $past(irqWr, 2))
        else $error("interrupt dropped without a flag or enable write");
    irq_off_a:
        assert property (wrAddr(16'h1022) ##0 busReq.wdata == 8'h00 |-> ##2 !irqReq)
        else $error("interrupt stays with all enables off");
    flag_keep_a:
        assert property (wrAddr(16'h1023) ##0 busReq.wdata == 8'h00 |=> (!$fell(irqReq)) [*2])
        else $error("writing zero cleared a flag");
endmodule : timer_capture_compare_asserts

bind timer_capture_compare timer_capture_compare_asserts timer_capture_compare_asserts_inst (
    .sys_clk(sys_clk), .arst_n(arst_n), .busReq(busReq), .rdData(rdData),
    .capPins(capPins), .cmpPins(cmpPins), .irqReq(irqReq));

// >>> tb/timer_capture_compare_bench.sv
// self-checking bench for the capture/compare channels
`timescale 1ns/1ps
module timer_capture_compare_bench;
    logic              sys_clk = 1'b0;
    logic              arst_n = 1'b0;
    tcc_pkg::bus_req_t busReq = '0;
    logic [7:0]        rdData;
    logic [3:0]        target = 4'h0;
    logic [3:0]        capPins;
    logic [4:0]        cmpPins;
    logic              irqReq;
    logic [31:0]       seed = 32'h18c7c386;
    int                failCount = 0;
    int                samplesChecked = 0;
    localparam int     sh[4] = '{4, 2, 0, 6};
    localparam int     fb[4] = '{2, 1, 0, 3};
    logic [1:0]        acts[5] = '{2'h3, 2'h1, 2'h2, 2'h1, 2'h0};

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    timer_capture_compare timer_capture_compare_inst (
        .sys_clk(sys_clk), .arst_n(arst_n), .busReq(busReq), .rdData(rdData),
        .capPins(capPins), .cmpPins(cmpPins), .irqReq(irqReq));
    tcc_event_source tcc_event_source_inst (
        .target(target), .sys_clk(sys_clk), .capPins(capPins));

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // pin level after one match with the given action
    function automatic logic nextPin(input logic [1:0] act, input logic p);
        case (act)
            2'h0: return p;
            2'h1: return ~p;
            default: return act[0];
        endcase
    endfunction : nextPin

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            failCount++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic put(input logic [15:0] a, input logic [7:0] d);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        busReq.wr <= 1'b0;
        @(posedge sys_clk);
    endtask : put

    task automatic get(input logic [15:0] a, output logic [7:0] d);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        busReq.rd <= 1'b0;
        #1 d = rdData;
        @(posedge sys_clk);
    endtask : get

    // write then read back with no gap
    task automatic putGet(input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        busReq <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        busReq.rd <= 1'b0;
        #1 q = rdData;
        @(posedge sys_clk);
    endtask : putGet

    task automatic put16(input logic [15:0] a, input logic [15:0] v);
        put(a, v[15:8]);
        put(a + 16'h1, v[7:0]);
    endtask : put16

    task automatic get16(input logic [15:0] a, output logic [15:0] v);
        get(a, v[15:8]);
        get(a + 16'h1, v[7:0]);
    endtask : get16

    // count read away from a low-byte carry
    task automatic now(output logic [15:0] t);
        do begin
            get16(16'h100e, t);
        end while (t[7:0] < 8'h04 || t[7:0] > 8'hf0);
    endtask : now

    task automatic finalReport();
        $display("checks %0d mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finalReport

    // watchdog
    initial begin
        #900000;
        failCount++;
        finalReport();
    end

    // main sequence
    initial begin
        logic [7:0]  q;
        logic [15:0] v;
        logic [15:0] w;
        logic [15:0] t;
        logic        p;
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        for (int a = 16'h1016; a < 16'h1020; a++) begin
            get(16'(a), q);
            check("cmp reset", 16'(q), 16'h00ff);
        end
        get(16'h1021, q);
        check("edge reset", 16'(q), 16'h0000);
        put(16'h1021, 8'hc0);
        put(16'h1023, 8'hff);
        target <= 4'h8;
        repeat (6) @(posedge sys_clk);
        get(16'h1023, q);
        check("ch4 off", 16'(q[3]), 16'h0);
        target <= 4'h0;
        for (int a = 16'h1016; a < 16'h1020; a++) begin
            v = 16'(rnd());
            putGet(16'(a), v[7:0], q);
            check("cmp rw", 16'(q), 16'(v[7:0]));
        end
        putGet(16'h1021, 8'h5a, q);
        check("edge rw", 16'(q), 16'h005a);
        put(16'h1026, 8'h04);
        for (int c = 0; c < 4; c++) begin
            for (int k = 0; k < 4; k++) begin
                put(16'h1021, 8'(k << sh[c]));
                for (int e = 0; e < 2; e++) begin
                    put(16'h1023, 8'hff);
                    target <= (e == 0) ? 4'(1 << c) : 4'h0;
                    repeat (6) @(posedge sys_clk);
                    get(16'h1023, q);
                    check("edge flag", 16'(q[fb[c]]), 16'(k[e]));
                end
            end
        end
        put(16'h1021, 8'h14);
        target <= 4'h3;
        repeat (6) @(posedge sys_clk);
        get16(16'h1010, v);
        get16(16'h1012, w);
        check("same count", w, v);
        put(16'h1021, 8'h00);
        put16(16'h1010, ~v);
        get16(16'h1010, w);
        check("capture read only", w, v);
        put(16'h1022, 8'h40);
        p = 1'b0;
        foreach (acts[i]) begin
            put(16'h1020, {acts[i], 6'h00});
            now(t);
            put16(16'h1018, t + 16'h8);
            repeat (60) @(posedge sys_clk);
            p = nextPin(acts[i], p);
            check("pin action", 16'(cmpPins[1]), 16'(p));
        end
        check("irq set", 16'(irqReq), 16'h1);
        q = 8'(rnd()) & 8'hb8;
        put(16'h100c, 8'hf8);
        put(16'h100d, q);
        put(16'h1020, 8'hc0);
        now(t);
        put16(16'h1016, t + 16'h10);
        put16(16'h1018, t + 16'h10);
        repeat (80) @(posedge sys_clk);
        for (int i = 0; i < 5; i++) begin
            w[i] = q[7 - i];
        end
        check("mask pins", 16'(cmpPins), 16'(w[4:0]));
        put(16'h1023, 8'h00);
        @(posedge sys_clk);
        check("flag kept", 16'(irqReq), 16'h1);
        put(16'h1023, 8'hff);
        @(posedge sys_clk);
        check("flag cleared", 16'(irqReq), 16'h0);
        put(16'h1022, 8'h00);
        finalReport();
    end
endmodule : timer_capture_compare_bench
